// [design/uda_pkg.sv]
package uda_pkg;

  // ==========================================================
  // Sizes
  localparam int          DATA_W       = 8;
  localparam int          FIFO_DEPTH   = 16;
  localparam int          PTR_W        = 4;
  localparam int          CNT_W        = 5;
  localparam logic [4:0]  FIFO_FULL    = 5'h10;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0]  OFF_DATA     = 8'h00;
  localparam logic [7:0]  OFF_IER_DLH  = 8'h04;
  localparam logic [7:0]  OFF_LCTL     = 8'h0C;
  localparam logic [7:0]  OFF_LSTAT    = 8'h14;
  localparam logic [7:0]  OFF_FCTL     = 8'h20;
  localparam logic [7:0]  OFF_EVT      = 8'h24;
  localparam logic [7:0]  OFF_MASK     = 8'h28;

  // ==========================================================
  // Field positions
  localparam int          LCTL_DIVISOR_LATCH_ACCESS_BIT    = 7;
  localparam int          FCTL_FEN     = 0;
  localparam int          LS_DR        = 0;
  localparam int          LS_OE        = 1;
  localparam int          LS_TX_HOLDING_EMPTY_FLAG      = 5;
  localparam int          LS_TEMT      = 6;
  localparam int          IE_RXAV      = 0;
  localparam int          IE_TXE       = 1;
  localparam int          IE_LS        = 2;
  localparam int          IE_MS        = 3;
  localparam int          EV_RXAV      = 0;
  localparam int          EV_LS        = 1;
  localparam int          EV_TXE       = 2;
  localparam int          EV_TMO       = 3;

  // ==========================================================
  // Reset values
  localparam logic [15:0] DIV_RST      = 16'h0000;
  localparam logic [3:0]  IER_RST      = 4'h0;
  localparam logic [7:0]  LCTL_RST     = 8'h00;
  localparam logic [3:0]  EVT_RST      = 4'h0;

  // ==========================================================
  // Cycle and tick counts
  localparam logic [3:0]  TICK_LAST    = 4'hF;
  localparam logic [3:0]  TICK_MID     = 4'h7;
  localparam logic [2:0]  BIT_LAST     = 3'h7;
  localparam logic [9:0]  TMO_TICKS    = 10'h280;

  typedef enum logic [3:0] {
    UDA_IDLE  = 4'b0001,
    UDA_START = 4'b0010,
    UDA_DATA  = 4'b0100,
    UDA_STOP  = 4'b1000
  } uda_ser_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } uda_wb_req_s;

endpackage

// [design/uda_baud.sv]
`timescale 1ns/100ps
`default_nettype none

module uda_baud (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] divisor,
  output logic             tick16
);

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] div_seen;
    logic        tick;
  } uda_baud_s;

  uda_baud_s s_r;
  uda_baud_s s_nxt;

  // ==========================================================
  // Divider: one tick every divisor cycles, sixteen ticks a bit
  always_comb begin
    s_nxt          = s_r;
    s_nxt.tick     = 1'b0;
    s_nxt.div_seen = divisor;
    if (divisor == 16'h0000) begin
      s_nxt.cnt = 16'h0000;
    end else if (divisor != s_r.div_seen) begin
      // Restart on a new divisor so no stale count is carried over
      s_nxt.cnt = 16'h0000;
    end else if (s_r.cnt == divisor - 16'h0001) begin
      s_nxt.cnt  = 16'h0000;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick16 = s_r.tick;

endmodule

`default_nettype wire

// [design/uda_top.sv]
// Functional notes
// - A read of the data location with latch access off returns the oldest received byte, valid while data-ready is 1.
// - With FIFOs off a new received byte overwrites an unread one and raises overrun.
// - With FIFOs on a data read returns and removes the head of the receive FIFO.
// - A byte arriving at a full receive FIFO is dropped, the stored bytes kept, and overrun raised, unless a data read pops the head in the same cycle.
// - Bytes written to the transmit view are sent out on the serial output.
// - With FIFOs off a write clears transmit-holding-empty and later writes overwrite the pending byte.
// - With FIFOs on writes queue up to the FIFO depth and a write to a full FIFO is dropped.
// - The baud divisor is 16-bit read/write and its low byte sits at the data location while latch access is 1.
// - Baud rate is the clock frequency over sixteen times the divisor.
// - A zero divisor stops the baud clock and all serial traffic.
// - Offset 0x4 is the interrupt-enable view with latch access 0 and the divisor high byte with it 1.
// - At offset 0x4 bits 7:0 are divisor high bits with latch access 1; with it 0 bits 3:0 are the enables, held apart from the divisor.
// - Enable bit 3 gates modem status and bit 2 gates receiver line status interrupts; here bit 3 is stored but gates nothing.
// - Enable bit 1 gates transmit-empty, bit 0 gates receive-available and, with FIFOs on, character timeout.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none

module uda_top (
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        SIN,
  output logic             SOUT,
  output logic             IRQ
);

  typedef struct packed {
    logic                   ack;
    logic [31:0]            rdata;
    logic                   irq;
    logic                   sout;
    logic [15:0]            div;
    logic [3:0]             ier;
    logic [7:0]             lctl;
    logic                   fen;
    logic [3:0]             evt;
    logic [3:0]             mask;
    logic                   overrun;
    logic                   sin_m;
    logic                   sin_s;
    logic [15:0][7:0]       rx_mem;
    logic [3:0]             rx_rd;
    logic [3:0]             rx_wr;
    logic [4:0]             rx_cnt;
    logic [15:0][7:0]       tx_mem;
    logic [3:0]             tx_rd;
    logic [3:0]             tx_wr;
    logic [4:0]             tx_cnt;
    uda_pkg::uda_ser_e      tx_st;
    logic [3:0]             tx_tk;
    logic [2:0]             tx_bit;
    logic [7:0]             tx_sh;
    uda_pkg::uda_ser_e      rx_st;
    logic [3:0]             rx_tk;
    logic [2:0]             rx_bit;
    logic [7:0]             rx_sh;
    logic [9:0]             tmo;
  } uda_top_s;

  uda_top_s              s_r;
  uda_top_s              s_nxt;
  uda_pkg::uda_wb_req_s  req;
  logic                  tick;

  assign req = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I, adr: WB_ADR_I, sel: WB_SEL_I, dat: WB_DAT_I};

  uda_baud u_baud (
    .clk     (CLK_SYS),
    .rst     (SYS_RST),
    .divisor (s_r.div),
    .tick16  (tick)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic       acc;
    logic       wr;
    logic       rd;
    logic       divisor_latch_access_bit;
    logic       rx_pop;
    logic       rx_done;
    logic       tx_push;
    logic       tx_pop;
    logic       ovr_set;
    logic       ls_read;
    logic       fen_chg;
    logic       tmo_hit;
    logic [3:0] evt_set;
    logic [3:0] evt_clr;
    acc     = 1'b0;
    wr      = 1'b0;
    rd      = 1'b0;
    divisor_latch_access_bit    = 1'b0;
    rx_pop  = 1'b0;
    rx_done = 1'b0;
    tx_push = 1'b0;
    tx_pop  = 1'b0;
    ovr_set = 1'b0;
    ls_read = 1'b0;
    fen_chg = 1'b0;
    tmo_hit = 1'b0;
    evt_set = 4'h0;
    evt_clr = 4'h0;
    s_nxt   = s_r;

    s_nxt.sin_m = SIN;
    s_nxt.sin_s = s_r.sin_m;

    // ========================================================
    // Wishbone slave: answer one cycle after the request is seen
    acc       = req.cyc & req.stb & ~s_r.ack;
    wr        = acc & req.we & req.sel[0];
    rd        = acc & ~req.we;
    divisor_latch_access_bit      = s_r.lctl[uda_pkg::LCTL_DIVISOR_LATCH_ACCESS_BIT];
    s_nxt.ack = acc;

    if (rd) begin
      s_nxt.rdata = 32'h0000_0000;
      unique case (req.adr)
        uda_pkg::OFF_DATA: begin
          if (divisor_latch_access_bit) begin
            s_nxt.rdata[7:0] = s_r.div[7:0];
          end else begin
            s_nxt.rdata[7:0] = s_r.rx_mem[s_r.rx_rd];
            rx_pop           = (s_r.rx_cnt != 5'h00);
          end
        end
        uda_pkg::OFF_IER_DLH: begin
          if (divisor_latch_access_bit) begin
            s_nxt.rdata[7:0] = s_r.div[15:8];
          end else begin
            s_nxt.rdata[3:0] = s_r.ier;
          end
        end
        uda_pkg::OFF_LCTL: begin
          s_nxt.rdata[7:0] = s_r.lctl;
        end
        uda_pkg::OFF_LSTAT: begin
          s_nxt.rdata[uda_pkg::LS_DR]   = (s_r.rx_cnt != 5'h00);
          s_nxt.rdata[uda_pkg::LS_OE]   = s_r.overrun;
          s_nxt.rdata[uda_pkg::LS_TX_HOLDING_EMPTY_FLAG] = (s_r.tx_cnt == 5'h00);
          s_nxt.rdata[uda_pkg::LS_TEMT] = (s_r.tx_cnt == 5'h00) & (s_r.tx_st == uda_pkg::UDA_IDLE);
          ls_read                       = 1'b1;
        end
        uda_pkg::OFF_FCTL: begin
          s_nxt.rdata[uda_pkg::FCTL_FEN] = s_r.fen;
        end
        uda_pkg::OFF_EVT: begin
          s_nxt.rdata[3:0] = s_r.evt;
        end
        uda_pkg::OFF_MASK: begin
          s_nxt.rdata[3:0] = s_r.mask;
        end
        default: begin
          s_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end

    if (wr) begin
      unique case (req.adr)
        uda_pkg::OFF_DATA: begin
          if (divisor_latch_access_bit) begin
            s_nxt.div[7:0] = req.dat[7:0];
          end else begin
            tx_push = 1'b1;
          end
        end
        uda_pkg::OFF_IER_DLH: begin
          if (divisor_latch_access_bit) begin
            s_nxt.div[15:8] = req.dat[7:0];
          end else begin
            s_nxt.ier = req.dat[3:0];
          end
        end
        uda_pkg::OFF_LCTL: begin
          s_nxt.lctl = req.dat[7:0];
        end
        uda_pkg::OFF_FCTL: begin
          fen_chg   = (req.dat[uda_pkg::FCTL_FEN] != s_r.fen);
          s_nxt.fen = req.dat[uda_pkg::FCTL_FEN];
        end
        uda_pkg::OFF_EVT: begin
          evt_clr = req.dat[3:0];
        end
        uda_pkg::OFF_MASK: begin
          s_nxt.mask = req.dat[3:0];
        end
        default: begin
          s_nxt.ack = acc;
        end
      endcase
    end

    // ========================================================
    // Transmit serializer, 16 ticks per bit, 8N1
    // A zero divisor never starts a frame, so nothing leaves the pin
    if (s_r.tx_st == uda_pkg::UDA_IDLE) begin
      if (s_r.tx_cnt != 5'h00 && s_r.div != 16'h0000) begin
        tx_pop       = 1'b1;
        s_nxt.tx_sh  = s_r.tx_mem[s_r.tx_rd];
        s_nxt.tx_st  = uda_pkg::UDA_START;
        s_nxt.tx_tk  = 4'h0;
        s_nxt.tx_bit = 3'h0;
      end
    end else if (tick) begin
      s_nxt.tx_tk = s_r.tx_tk + 4'h1;
      if (s_r.tx_tk == uda_pkg::TICK_LAST) begin
        unique case (s_r.tx_st)
          uda_pkg::UDA_START: begin
            s_nxt.tx_st = uda_pkg::UDA_DATA;
          end
          uda_pkg::UDA_DATA: begin
            s_nxt.tx_sh  = {1'b1, s_r.tx_sh[7:1]};
            s_nxt.tx_bit = s_r.tx_bit + 3'h1;
            if (s_r.tx_bit == uda_pkg::BIT_LAST) begin
              s_nxt.tx_st = uda_pkg::UDA_STOP;
            end
          end
          default: begin
            s_nxt.tx_st = uda_pkg::UDA_IDLE;
          end
        endcase
      end
    end
    s_nxt.sout = (s_nxt.tx_st == uda_pkg::UDA_START) ? 1'b0 :
                 (s_nxt.tx_st == uda_pkg::UDA_DATA)  ? s_nxt.tx_sh[0] : 1'b1;

    // ========================================================
    // Transmit holding: one overwritable slot, or a FIFO
    if (!s_r.fen) begin
      if (tx_push) begin
        s_nxt.tx_mem[s_r.tx_rd] = req.dat[7:0];
        s_nxt.tx_cnt            = 5'h01;
      end else if (tx_pop) begin
        s_nxt.tx_cnt = 5'h00;
      end
    end else begin
      if (tx_pop) begin
        s_nxt.tx_rd = s_r.tx_rd + 4'h1;
      end
      // A write while full is lost; a pop in the same cycle does not free room for it
      if (tx_push && s_r.tx_cnt != uda_pkg::FIFO_FULL) begin
        s_nxt.tx_mem[s_r.tx_wr] = req.dat[7:0];
        s_nxt.tx_wr             = s_r.tx_wr + 4'h1;
      end else begin
        tx_push = 1'b0;
      end
      s_nxt.tx_cnt = s_r.tx_cnt + {4'h0, tx_push} - {4'h0, tx_pop};
    end

    // ========================================================
    // Receive deserializer, sampled mid-bit
    if (tick) begin
      s_nxt.rx_tk = s_r.rx_tk + 4'h1;
      unique case (s_r.rx_st)
        uda_pkg::UDA_IDLE: begin
          s_nxt.rx_tk = 4'h0;
          if (!s_r.sin_s) begin
            s_nxt.rx_st = uda_pkg::UDA_START;
          end
        end
        uda_pkg::UDA_START: begin
          if (s_r.rx_tk == uda_pkg::TICK_MID) begin
            s_nxt.rx_tk  = 4'h0;
            s_nxt.rx_bit = 3'h0;
            s_nxt.rx_st  = s_r.sin_s ? uda_pkg::UDA_IDLE : uda_pkg::UDA_DATA;
          end
        end
        uda_pkg::UDA_DATA: begin
          if (s_r.rx_tk == uda_pkg::TICK_LAST) begin
            s_nxt.rx_sh  = {s_r.sin_s, s_r.rx_sh[7:1]};
            s_nxt.rx_bit = s_r.rx_bit + 3'h1;
            if (s_r.rx_bit == uda_pkg::BIT_LAST) begin
              s_nxt.rx_st = uda_pkg::UDA_STOP;
            end
          end
        end
        default: begin
          if (s_r.rx_tk == uda_pkg::TICK_LAST) begin
            rx_done     = s_r.sin_s;
            s_nxt.rx_st = uda_pkg::UDA_IDLE;
          end
        end
      endcase
    end

    // ========================================================
    // Receive buffer: one slot, or a FIFO
    if (!s_r.fen) begin
      if (rx_done) begin
        s_nxt.rx_mem[s_r.rx_rd] = s_r.rx_sh;
        s_nxt.rx_cnt            = 5'h01;
        ovr_set                 = (s_r.rx_cnt != 5'h00) & ~rx_pop;
      end else if (rx_pop) begin
        s_nxt.rx_cnt = 5'h00;
      end
    end else begin
      if (rx_pop) begin
        s_nxt.rx_rd = s_r.rx_rd + 4'h1;
      end
      if (rx_done && (s_r.rx_cnt != uda_pkg::FIFO_FULL || rx_pop)) begin
        s_nxt.rx_mem[s_r.rx_wr] = s_r.rx_sh;
        s_nxt.rx_wr             = s_r.rx_wr + 4'h1;
      end else begin
        ovr_set = rx_done;
        rx_done = 1'b0;
      end
      s_nxt.rx_cnt = s_r.rx_cnt + {4'h0, rx_done} - {4'h0, rx_pop};
    end

    // Toggling FIFO enable empties both paths
    if (fen_chg) begin
      s_nxt.rx_rd  = 4'h0;
      s_nxt.rx_wr  = 4'h0;
      s_nxt.rx_cnt = 5'h00;
      s_nxt.tx_rd  = 4'h0;
      s_nxt.tx_wr  = 4'h0;
      s_nxt.tx_cnt = 5'h00;
    end

    // Overrun is read-to-clear; a new overrun in the read cycle survives
    s_nxt.overrun = (s_r.overrun & ~ls_read) | ovr_set;

    // ========================================================
    // Character timeout: four frames of silence with data waiting
    if (!s_r.fen || s_r.rx_cnt == 5'h00 || rx_done || rx_pop) begin
      s_nxt.tmo = 10'h000;
    end else if (tick && s_r.tmo != uda_pkg::TMO_TICKS) begin
      s_nxt.tmo = s_r.tmo + 10'h001;
      tmo_hit   = (s_r.tmo == uda_pkg::TMO_TICKS - 10'h001);
    end

    // ========================================================
    // Events gated by the enables; modem status has no source here
    evt_set[uda_pkg::EV_RXAV] = rx_done & s_r.ier[uda_pkg::IE_RXAV];
    evt_set[uda_pkg::EV_TMO]  = tmo_hit & s_r.ier[uda_pkg::IE_RXAV];
    evt_set[uda_pkg::EV_TXE]  = tx_pop & (s_nxt.tx_cnt == 5'h00) & s_r.ier[uda_pkg::IE_TXE];
    evt_set[uda_pkg::EV_LS]   = ovr_set & s_r.ier[uda_pkg::IE_LS];
    s_nxt.evt = (s_r.evt & ~evt_clr) | evt_set;
    s_nxt.irq = |(s_nxt.evt & s_nxt.mask);
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      s_r       <= '0;
      s_r.div   <= uda_pkg::DIV_RST;
      s_r.ier   <= uda_pkg::IER_RST;
      s_r.lctl  <= uda_pkg::LCTL_RST;
      s_r.evt   <= uda_pkg::EVT_RST;
      s_r.sout  <= 1'b1;
      s_r.sin_m <= 1'b1;
      s_r.sin_s <= 1'b1;
      s_r.tx_st <= uda_pkg::UDA_IDLE;
      s_r.rx_st <= uda_pkg::UDA_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign WB_DAT_O = s_r.rdata;
  assign WB_ACK_O = s_r.ack;
  assign SOUT     = s_r.sout;
  assign IRQ      = s_r.irq;

endmodule

`default_nettype wire

// [tb/uda_monitor.sv]
`timescale 1ns/100ps
`default_nettype none

module uda_monitor (
  input wire logic        CLK_SYS,
  input wire logic        SYS_RST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        SIN,
  input wire logic        SOUT,
  input wire logic        IRQ
);
  // ==========================================================
  // Shadow of what software wrote, so reads and the line can be judged
  logic        take;
  logic        wr;
  logic        divisor_latch_access_bit_r;
  logic [7:0]  div_lo_r;
  logic [7:0]  div_hi_r;
  logic [3:0]  ier_r;
  logic [3:0]  mask_r;
  logic [7:0]  exp_r;
  logic        chk_r;
  logic [15:0] div;

  assign take = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr   = take & WB_WE_I & WB_SEL_I[0];
  assign div  = {div_hi_r, div_lo_r};

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      divisor_latch_access_bit_r   <= 1'b0;
      div_lo_r <= 8'h00;
      div_hi_r <= 8'h00;
      ier_r    <= 4'h0;
      mask_r   <= 4'h0;
      exp_r    <= 8'h00;
      chk_r    <= 1'b0;
    end else begin
      chk_r <= take & ~WB_WE_I & ((WB_ADR_I == uda_pkg::OFF_DATA && divisor_latch_access_bit_r) || WB_ADR_I == uda_pkg::OFF_IER_DLH);
      exp_r <= (WB_ADR_I == uda_pkg::OFF_DATA) ? div_lo_r : (divisor_latch_access_bit_r ? div_hi_r : {4'h0, ier_r});
      if (wr && WB_ADR_I == uda_pkg::OFF_LCTL) divisor_latch_access_bit_r <= WB_DAT_I[7];
      if (wr && WB_ADR_I == uda_pkg::OFF_DATA && divisor_latch_access_bit_r) div_lo_r <= WB_DAT_I[7:0];
      if (wr && WB_ADR_I == uda_pkg::OFF_IER_DLH && divisor_latch_access_bit_r) div_hi_r <= WB_DAT_I[7:0];
      if (wr && WB_ADR_I == uda_pkg::OFF_IER_DLH && !divisor_latch_access_bit_r) ier_r <= WB_DAT_I[3:0];
      if (wr && WB_ADR_I == uda_pkg::OFF_MASK) mask_r <= WB_DAT_I[3:0];
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge CLK_SYS); endclocking

  sequence s_take;
    take;
  endsequence
  sequence s_low16;
    (!SOUT)[*8] ##1 (!SOUT)[*8];
  endsequence

  property p_ack_one;   disable iff (SYS_RST) s_take |=> WB_ACK_O;                            endproperty
  property p_ack_pulse; disable iff (SYS_RST) WB_ACK_O |=> !WB_ACK_O;                         endproperty
  property p_rst;       SYS_RST |=> (!WB_ACK_O && SOUT && !IRQ);                              endproperty
  property p_view;      disable iff (SYS_RST) chk_r |-> WB_DAT_O[7:0] == exp_r;               endproperty
  property p_rsvd;      disable iff (SYS_RST) WB_ACK_O && !$past(WB_WE_I) |-> WB_DAT_O[31:8] == 24'h0; endproperty
  property p_irq_mask;  disable iff (SYS_RST) mask_r == 4'h0 && $past(mask_r) == 4'h0 |-> !IRQ; endproperty
  property p_div_zero;  disable iff (SYS_RST) div == 16'h0000 && SOUT |=> SOUT;               endproperty
  property p_bit_len;   disable iff (SYS_RST) $fell(SOUT) && div == 16'h0001 |-> s_low16;     endproperty

  a_ack_one:   assert property (p_ack_one)   else $error("ack missing one cycle after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_rst:       assert property (p_rst)       else $error("outputs not idle during reset");
  a_view:      assert property (p_view)      else $error("divisor or enable view read wrong");
  a_rsvd:      assert property (p_rsvd)      else $error("reserved read bits not zero");
  a_irq_mask:  assert property (p_irq_mask)  else $error("interrupt raised with mask clear");
  a_div_zero:  assert property (p_div_zero)  else $error("line moved with zero divisor");
  a_bit_len:   assert property (p_bit_len)   else $error("low bit shorter than sixteen ticks");
endmodule

bind uda_top uda_monitor uda_monitor_inst (
  .CLK_SYS  (CLK_SYS),
  .SYS_RST  (SYS_RST),
  .WB_CYC_I (WB_CYC_I),
  .WB_STB_I (WB_STB_I),
  .WB_WE_I  (WB_WE_I),
  .WB_ADR_I (WB_ADR_I),
  .WB_SEL_I (WB_SEL_I),
  .WB_DAT_I (WB_DAT_I),
  .WB_DAT_O (WB_DAT_O),
  .WB_ACK_O (WB_ACK_O),
  .SIN      (SIN),
  .SOUT     (SOUT),
  .IRQ      (IRQ)
);
`default_nettype wire

// [tb/uda_partner.sv]
`timescale 1ns/100ps
`default_nettype none

module uda_partner #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk,
  input  wire logic sout,
  output var logic  sin
);
  logic [7:0] rx_q[$];

  // Idle line rests high between frames
  initial sin = 1'b1;

  // ==========================================================
  // Sender: gap adds idle bit times for a slow partner
  task automatic send(input logic [7:0] b, input int gap);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10 + gap; i++) begin
      sin <= (i < 10) ? frame[i] : 1'b1;
      repeat (BIT_CLKS) @(posedge clk);
    end
  endtask

  // ==========================================================
  // Receiver samples mid-bit; a bad stop bit drops the byte
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge sout);
      repeat (BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge clk);
        b[i] = sout;
      end
      repeat (BIT_CLKS) @(posedge clk);
      if (sout === 1'b1) rx_q.push_back(b);
    end
  end
endmodule
`default_nettype wire

// [tb/uda_top_test.sv]
`timescale 1ns/100ps
`default_nettype none

module uda_top_test;
  logic                 clk_sys = 1'b0;
  logic                 sys_rst = 1'b1;
  uda_pkg::uda_wb_req_s req     = '0;
  logic [31:0]          dat_o;
  logic [31:0]          rd;
  logic                 ack;
  logic                 sin;
  logic                 sout;
  logic                 irq;
  int                   n_fail      = 0;
  int                   check_count = 0;

  always #10 clk_sys = ~clk_sys;

  uda_top uda_top_inst (
    .CLK_SYS  (clk_sys),
    .SYS_RST  (sys_rst),
    .WB_CYC_I (req.cyc),
    .WB_STB_I (req.stb),
    .WB_WE_I  (req.we),
    .WB_ADR_I (req.adr),
    .WB_SEL_I (req.sel),
    .WB_DAT_I (req.dat),
    .WB_DAT_O (dat_o),
    .WB_ACK_O (ack),
    .SIN      (sin),
    .SOUT     (sout),
    .IRQ      (irq)
  );

  uda_partner #(.BIT_CLKS(16)) uda_partner_inst (.clk(clk_sys), .sout(sout), .sin(sin));

  // ==========================================================
  // Tasks
  task automatic end_of_test();
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Classic cycle: hold until ack is sampled, take data there, then idle one cycle
  // No local limit: only the watchdog may end a wait for ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    rd = dat_o;
    req <= '0;
    @(posedge clk_sys);
  endtask

  task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk8(nm, e, rd[7:0] & m);
  endtask

  task automatic wait_tx_holding_empty_flag();
    int k;
    k = 0;
    do begin
      wb(1'b0, uda_pkg::OFF_LSTAT, 32'h0);
      k++;
    end while (rd[5] !== 1'b1 && k < 200);
  endtask

  task automatic wait_q(input int n);
    int k;
    k = 0;
    while (uda_partner_inst.rx_q.size() < n && k < 4000) begin
      @(posedge clk_sys);
      k++;
    end
    repeat (200) @(posedge clk_sys);
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk8("irq", 8'h00, {7'h00, irq});
    rdm(uda_pkg::OFF_IER_DLH, 8'hFF, 8'h00, "enables");
    wb(1'b1, uda_pkg::OFF_LCTL, 32'h80);
    rdm(uda_pkg::OFF_DATA, 8'hFF, 8'h00, "div low");
    rdm(uda_pkg::OFF_IER_DLH, 8'hFF, 8'h00, "div high");
    wb(1'b1, uda_pkg::OFF_DATA, 32'hA5);
    wb(1'b1, uda_pkg::OFF_IER_DLH, 32'h3C);
    rdm(uda_pkg::OFF_DATA, 8'hFF, 8'hA5, "div low");
    rdm(uda_pkg::OFF_IER_DLH, 8'hFF, 8'h3C, "div high");
    wb(1'b1, uda_pkg::OFF_LCTL, 32'h00);
    rdm(uda_pkg::OFF_IER_DLH, 8'hFF, 8'h00, "enables");
    wb(1'b1, uda_pkg::OFF_IER_DLH, 32'h0F);
    rdm(uda_pkg::OFF_IER_DLH, 8'h0F, 8'h0F, "enables");
    rdm(8'h3C, 8'hFF, 8'h00, "unmapped");
    wb(1'b1, uda_pkg::OFF_LCTL, 32'h80);
    rdm(uda_pkg::OFF_IER_DLH, 8'hFF, 8'h3C, "div high");
    wb(1'b1, uda_pkg::OFF_IER_DLH, 32'h00);
    wb(1'b1, uda_pkg::OFF_DATA, 32'h00);
    wb(1'b1, uda_pkg::OFF_LCTL, 32'h00);
    // A byte queued while the divisor is zero must wait
    wb(1'b1, uda_pkg::OFF_DATA, 32'h77);
    repeat (100) begin
      @(posedge clk_sys);
      chk8("line idle", 8'h01, {7'h00, sout});
    end
    wb(1'b1, uda_pkg::OFF_LCTL, 32'h80);
    wb(1'b1, uda_pkg::OFF_DATA, 32'h01);
    wb(1'b1, uda_pkg::OFF_LCTL, 32'h00);
    repeat (8) @(posedge clk_sys);
    wait_tx_holding_empty_flag();
    wb(1'b1, uda_pkg::OFF_DATA, 32'h11);
    rdm(uda_pkg::OFF_LSTAT, 8'h20, 8'h00, "holding empty");
    wb(1'b1, uda_pkg::OFF_DATA, 32'h22);
    wait_q(2);
    chk8("tx count", 8'h02, 8'(uda_partner_inst.rx_q.size()));
    chk8("tx byte", 8'h77, uda_partner_inst.rx_q[0]);
    chk8("tx byte", 8'h22, uda_partner_inst.rx_q[1]);
    uda_partner_inst.rx_q.delete();
    wb(1'b1, uda_pkg::OFF_FCTL, 32'h01);
    wait_tx_holding_empty_flag();
    for (int i = 0; i < 18; i++) wb(1'b1, uda_pkg::OFF_DATA, 32'h40 + i);
    wait_q(17);
    chk8("tx count", 8'h11, 8'(uda_partner_inst.rx_q.size()));
    for (int i = 0; i < 17; i++) chk8("tx byte", 8'h40 + 8'(i), uda_partner_inst.rx_q[i]);
    wb(1'b1, uda_pkg::OFF_FCTL, 32'h00);
    wb(1'b1, uda_pkg::OFF_MASK, 32'h01);
    uda_partner_inst.send(8'hC3, 1);
    chk8("irq", 8'h01, {7'h00, irq});
    rdm(uda_pkg::OFF_LSTAT, 8'h01, 8'h01, "data ready");
    rdm(uda_pkg::OFF_DATA, 8'hFF, 8'hC3, "rx byte");
    wb(1'b1, uda_pkg::OFF_EVT, 32'h01);
    chk8("irq", 8'h00, {7'h00, irq});
    wb(1'b1, uda_pkg::OFF_MASK, 32'h00);
    uda_partner_inst.send(8'h12, 0);
    uda_partner_inst.send(8'h34, 1);
    chk8("irq", 8'h00, {7'h00, irq});
    rdm(uda_pkg::OFF_EVT, 8'h03, 8'h03, "rx and line events");
    rdm(uda_pkg::OFF_LSTAT, 8'h02, 8'h02, "overrun");
    rdm(uda_pkg::OFF_DATA, 8'hFF, 8'h34, "rx byte");
    wb(1'b1, uda_pkg::OFF_FCTL, 32'h01);
    for (int i = 0; i < 17; i++) uda_partner_inst.send(8'h80 + 8'(i), 0);
    repeat (8) @(posedge clk_sys);
    rdm(uda_pkg::OFF_LSTAT, 8'h03, 8'h03, "full overrun");
    for (int i = 0; i < 16; i++) rdm(uda_pkg::OFF_DATA, 8'hFF, 8'h80 + 8'(i), "rx fifo");
    rdm(uda_pkg::OFF_LSTAT, 8'h01, 8'h00, "drained");
    end_of_test();
  end

  // Whole run needs about 7000 cycles; this leaves generous slack
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    end_of_test();
  end
endmodule
`default_nettype wire
